// File: pct_pkg.sv
// Register map, field layout and state types of the countdown timer
package pct_pkg;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam logic [5:0] IDX_MODE = 6'h2a;
  localparam logic [5:0] IDX_PSC_LO = 6'h2b;
  localparam logic [5:0] IDX_RLD_HI = 6'h2c;
  localparam logic [5:0] IDX_RLD_LO = 6'h2d;
  localparam logic [5:0] IDX_CNT_HI = 6'h2e;
  localparam logic [5:0] IDX_CNT_LO = 6'h2f;
  localparam logic [5:0] IDX_CTRL = 6'h0c;
  localparam logic [5:0] IDX_RXMODE = 6'h13;
  localparam logic [5:0] IDX_CFG = 6'h10;
  localparam logic [5:0] IDX_STS = 6'h11;
  localparam logic [5:0] IDX_MASK = 6'h12;
  localparam int CTRL_STOP_BIT = 7;
  localparam int CTRL_START_BIT = 6;
  localparam int RXMODE_MULT_BIT = 2;
  localparam int CFG_EVEN_BIT = 0;
  localparam int CFG_RFON_BIT = 1;
  localparam int STS_EXP_BIT = 0;
  localparam int STS_RUN_BIT = 7;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] RXBITS_106K = 3'h5;
  localparam logic [2:0] RXBITS_OTHER = 3'h4;
  localparam logic [1:0] GATE_NONE = 2'h0;
  localparam logic [1:0] GATE_SIG = 2'h1;
  localparam logic [1:0] GATE_AUX = 2'h2;
  localparam logic [1:0] GATE_ADR = 2'h3;

  typedef struct packed {
    logic auto_start_enable;
    logic [1:0] gate_select;
    logic auto_reload_enable;
    logic [3:0] prescale_high_nibble;
  } pct_mode_t;

  typedef struct packed {
    logic tx_end;
    logic rf_field_on;
    logic rx_bit;
    logic proto_106k;
  } pct_proto_t;

  typedef enum logic {PCT_IDLE = 1'b0, PCT_RUN = 1'b1} pct_state_t;
endpackage : pct_pkg

// File: pct_timer.sv
// Protocol-aware 16-bit countdown timer with Avalon-MM register slave
`timescale 1ns/1ps
module pct_timer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [pct_pkg::AW-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [pct_pkg::DW-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [pct_pkg::DW-1:0] readdata,
  output logic waitrequest,
  input wire pct_pkg::pct_proto_t proto,
  input wire logic signal_input_pin,
  input wire logic auxiliary_pin_one,
  input wire logic address_pin_three,
  output logic timer_running_flag,
  output logic expiry_flag,
  output logic irq
);
  pct_pkg::pct_mode_t mode_r;
  pct_pkg::pct_state_t state_r;
  logic [7:0] prescale_low_byte_r;
  logic [7:0] reload_high_byte_r;
  logic [7:0] reload_low_byte_r;
  logic even_divide_select_r;
  logic initial_field_on_r;
  logic receive_multiple_r;
  logic [7:0] sts_r;
  logic [7:0] mask_r;
  logic [15:0] cnt_r;
  logic [12:0] psc_cnt_r;
  logic [2:0] rxcnt_r;
  logic ack_r;
  logic [pct_pkg::DW-1:0] rdata_r;
  logic [5:0] idx;
  logic wr_ok;
  logic rd_ok;
  logic rd_req;
  logic [12:0] psc_lim;
  logic [15:0] reload_val;
  logic gate_ok;
  logic tick;
  logic at_end;
  logic run;
  logic stop_cmd;
  logic sw_start;
  logic auto_start;
  logic start_evt;
  logic auto_stop;
  logic end_stop;
  logic [2:0] rx_lim;

  // One wait cycle per access keeps read data registered
  assign waitrequest = (read | write) & ~ack_r;
  assign idx = address[7:2];
  assign wr_ok = write & ack_r & byteenable[0];
  assign rd_ok = read & ack_r;
  assign rd_req = read & ~ack_r;
  assign readdata = rdata_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (read | write) & ~ack_r;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_r <= pct_pkg::MODE_RST;
      prescale_low_byte_r <= pct_pkg::BYTE_RST;
      reload_high_byte_r <= pct_pkg::BYTE_RST;
      reload_low_byte_r <= pct_pkg::BYTE_RST;
      even_divide_select_r <= 1'b0;
      initial_field_on_r <= 1'b0;
      receive_multiple_r <= 1'b0;
      mask_r <= pct_pkg::BYTE_RST;
    end else if (wr_ok) begin
      unique case (idx)
        pct_pkg::IDX_MODE: mode_r <= writedata[7:0];
        pct_pkg::IDX_PSC_LO: prescale_low_byte_r <= writedata[7:0];
        pct_pkg::IDX_RLD_HI: reload_high_byte_r <= writedata[7:0];
        pct_pkg::IDX_RLD_LO: reload_low_byte_r <= writedata[7:0];
        pct_pkg::IDX_RXMODE: begin
          receive_multiple_r <= writedata[pct_pkg::RXMODE_MULT_BIT];
        end
        pct_pkg::IDX_CFG: begin
          even_divide_select_r <= writedata[pct_pkg::CFG_EVEN_BIT];
          initial_field_on_r <= writedata[pct_pkg::CFG_RFON_BIT];
        end
        pct_pkg::IDX_MASK: mask_r <= writedata[7:0];
        default: ;
      endcase
    end
  end

  // Command bits are strobes and read back as zero
  assign stop_cmd = wr_ok && idx == pct_pkg::IDX_CTRL &&
                    writedata[pct_pkg::CTRL_STOP_BIT];
  assign sw_start = wr_ok && idx == pct_pkg::IDX_CTRL &&
                    writedata[pct_pkg::CTRL_START_BIT];

  assign reload_val = {reload_high_byte_r, reload_low_byte_r};
  // Period is 2P+1 or 2P+2 cycles: count 0 up to 2P+even
  assign psc_lim = {mode_r.prescale_high_nibble, prescale_low_byte_r,
                    even_divide_select_r};
  assign run = state_r == pct_pkg::PCT_RUN;

  always_comb begin
    unique case (mode_r.gate_select)
      pct_pkg::GATE_NONE: gate_ok = 1'b1;
      pct_pkg::GATE_SIG: gate_ok = signal_input_pin;
      pct_pkg::GATE_AUX: gate_ok = auxiliary_pin_one;
      pct_pkg::GATE_ADR: gate_ok = address_pin_three;
    endcase
  end

  assign tick = run && gate_ok && psc_cnt_r == psc_lim;
  assign at_end = tick && cnt_r == 16'h0000;
  assign end_stop = at_end && !mode_r.auto_reload_enable;

  assign auto_start = mode_r.auto_start_enable &&
                      (proto.tx_end ||
                       (initial_field_on_r && proto.rf_field_on));
  assign start_evt = sw_start || auto_start;
  assign rx_lim = proto.proto_106k ? pct_pkg::RXBITS_106K
                                   : pct_pkg::RXBITS_OTHER;
  assign auto_stop = run && mode_r.auto_start_enable &&
                     !receive_multiple_r && proto.rx_bit &&
                     3'(rxcnt_r + 3'h1) == rx_lim;

  // A stop command outranks a start in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= pct_pkg::PCT_IDLE;
    end else if (stop_cmd || auto_stop) begin
      state_r <= pct_pkg::PCT_IDLE;
    end else if (start_evt) begin
      state_r <= pct_pkg::PCT_RUN;
    end else if (end_stop) begin
      state_r <= pct_pkg::PCT_IDLE;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r <= 16'h0000;
    end else if (start_evt && !stop_cmd && !auto_stop) begin
      cnt_r <= reload_val;
    end else if (at_end && mode_r.auto_reload_enable) begin
      cnt_r <= reload_val;
    end else if (tick && cnt_r != 16'h0000) begin
      cnt_r <= 16'(cnt_r - 16'h0001);
    end
  end

  // Prescaler halts with the gate so partial periods resume
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      psc_cnt_r <= 13'h0000;
    end else if (start_evt || !run) begin
      psc_cnt_r <= 13'h0000;
    end else if (tick) begin
      psc_cnt_r <= 13'h0000;
    end else if (gate_ok) begin
      psc_cnt_r <= 13'(psc_cnt_r + 13'h0001);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rxcnt_r <= 3'h0;
    end else if (start_evt || !run) begin
      rxcnt_r <= 3'h0;
    end else if (proto.rx_bit && rxcnt_r != 3'h7) begin
      rxcnt_r <= 3'(rxcnt_r + 3'h1);
    end
  end

  // Read clears only what it returned, so later and same-cycle sets survive
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sts_r <= 8'h00;
    end else begin
      if (rd_ok && idx == pct_pkg::IDX_STS) begin
        sts_r <= sts_r & ~rdata_r[7:0];
      end
      if (at_end) begin
        sts_r[pct_pkg::STS_EXP_BIT] <= 1'b1;
      end
    end
  end

  assign expiry_flag = sts_r[pct_pkg::STS_EXP_BIT];
  assign timer_running_flag = run;
  assign irq = |(sts_r & mask_r);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_req) begin
      // Captured in the request cycle so data stand while waitrequest is low
      rdata_r <= 32'h0000_0000;
      unique case (idx)
        pct_pkg::IDX_MODE: rdata_r[7:0] <= mode_r;
        pct_pkg::IDX_PSC_LO: rdata_r[7:0] <= prescale_low_byte_r;
        pct_pkg::IDX_RLD_HI: rdata_r[7:0] <= reload_high_byte_r;
        pct_pkg::IDX_RLD_LO: rdata_r[7:0] <= reload_low_byte_r;
        pct_pkg::IDX_CNT_HI: rdata_r[7:0] <= cnt_r[15:8];
        pct_pkg::IDX_CNT_LO: rdata_r[7:0] <= cnt_r[7:0];
        pct_pkg::IDX_RXMODE: begin
          rdata_r[pct_pkg::RXMODE_MULT_BIT] <= receive_multiple_r;
        end
        pct_pkg::IDX_CFG: begin
          rdata_r[pct_pkg::CFG_EVEN_BIT] <= even_divide_select_r;
          rdata_r[pct_pkg::CFG_RFON_BIT] <= initial_field_on_r;
        end
        pct_pkg::IDX_STS: begin
          rdata_r[7:0] <= sts_r;
          rdata_r[pct_pkg::STS_RUN_BIT] <= run;
        end
        pct_pkg::IDX_MASK: rdata_r[7:0] <= mask_r;
        default: ;
      endcase
    end
  end

  sequence s_tx_start;
    mode_r.auto_start_enable && proto.tx_end && !stop_cmd && !auto_stop;
  endsequence

  sequence s_loaded;
    run && cnt_r == $past(reload_val);
  endsequence

  property p_auto_tx;
    @(posedge mclk) disable iff (rst) s_tx_start |=> s_loaded;
  endproperty
  a_auto_tx: assert property (p_auto_tx)
    else $error("transmission end did not start timer");

  property p_rf_on;
    @(posedge mclk) disable iff (rst)
      mode_r.auto_start_enable && initial_field_on_r && proto.rf_field_on
      && !stop_cmd && !auto_stop |=> run;
  endproperty
  a_rf_on: assert property (p_rf_on)
    else $error("field on did not start timer");

  property p_stop5;
    @(posedge mclk) disable iff (rst)
      run && mode_r.auto_start_enable && !receive_multiple_r &&
      proto.proto_106k && proto.rx_bit && rxcnt_r == 3'h4 |=> !run;
  endproperty
  a_stop5: assert property (p_stop5)
    else $error("no stop after fifth bit");

  property p_stop4;
    @(posedge mclk) disable iff (rst)
      run && mode_r.auto_start_enable && !receive_multiple_r &&
      !proto.proto_106k && proto.rx_bit && rxcnt_r == 3'h3 |=> !run;
  endproperty
  a_stop4: assert property (p_stop4)
    else $error("no stop after fourth bit");

  property p_multi;
    @(posedge mclk) disable iff (rst)
      run && receive_multiple_r && proto.rx_bit && !stop_cmd &&
      !end_stop |=> run;
  endproperty
  a_multi: assert property (p_multi)
    else $error("timer stopped on bits with receive-multiple");

  property p_stop_now;
    @(posedge mclk) disable iff (rst)
      stop_cmd |=> !run ##1 (!run || $past(start_evt));
  endproperty
  a_stop_now: assert property (p_stop_now)
    else $error("stop command ignored");

  property p_no_proto;
    @(posedge mclk) disable iff (rst)
      !mode_r.auto_start_enable && !sw_start && !run |=> !run;
  endproperty
  a_no_proto: assert property (p_no_proto)
    else $error("protocol event started timer");

  property p_reload;
    @(posedge mclk) disable iff (rst)
      at_end && mode_r.auto_reload_enable && !stop_cmd && !auto_stop
      |=> run && cnt_r == $past(reload_val) && expiry_flag;
  endproperty
  a_reload: assert property (p_reload)
    else $error("auto-reload failed");

  property p_expire;
    @(posedge mclk) disable iff (rst)
      end_stop && !start_evt |=> !run && expiry_flag && cnt_r == 16'h0000;
  endproperty
  a_expire: assert property (p_expire)
    else $error("expiry did not stop and flag");

  property p_decrement;
    @(posedge mclk) disable iff (rst)
      tick && cnt_r != 16'h0000 && !start_evt && !stop_cmd && !auto_stop
      |=> cnt_r == 16'($past(cnt_r) - 16'h0001);
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("counter did not step by one");

  property p_gate_hold;
    @(posedge mclk) disable iff (rst)
      run && !gate_ok && !start_evt && !stop_cmd && !auto_stop
      |=> $stable(cnt_r);
  endproperty
  a_gate_hold: assert property (p_gate_hold)
    else $error("counter moved while gate closed");

  property p_period;
    @(posedge mclk) disable iff (rst)
      tick ##1 (run && gate_ok && !start_evt && psc_lim == 13'h0001) [*2]
      |-> tick;
  endproperty
  a_period: assert property (p_period)
    else $error("prescaler period wrong");

  property p_exp_set;
    @(posedge mclk) disable iff (rst) at_end |=> expiry_flag;
  endproperty
  a_exp_set: assert property (p_exp_set)
    else $error("expiry event lost");

  property p_sts_clear;
    @(posedge mclk) disable iff (rst)
      rd_ok && idx == pct_pkg::IDX_STS && rdata_r[pct_pkg::STS_EXP_BIT]
      && !at_end |=> !expiry_flag;
  endproperty
  a_sts_clear: assert property (p_sts_clear)
    else $error("status read did not clear expiry");

  sequence s_start;
    start_evt && !stop_cmd && !auto_stop;
  endsequence

  property p_start_load;
    @(posedge mclk) disable iff (rst)
      s_start |=> s_loaded ##0 psc_cnt_r == 13'h0000 && rxcnt_r == 3'h0;
  endproperty
  a_start_load: assert property (p_start_load)
    else $error("start did not load reload value");

  property p_run_read;
    @(posedge mclk) disable iff (rst)
      rd_req && idx == pct_pkg::IDX_STS
      |=> rdata_r[pct_pkg::STS_RUN_BIT] == $past(run);
  endproperty
  a_run_read: assert property (p_run_read)
    else $error("status read lost running state");

  property p_ro_count;
    @(posedge mclk) disable iff (rst)
      wr_ok && idx == pct_pkg::IDX_CNT_HI && !run && !start_evt
      |=> $stable(cnt_r);
  endproperty
  a_ro_count: assert property (p_ro_count)
    else $error("count byte took a write");
endmodule : pct_timer

// File: pct_timer_tb.sv
// Self-checking testbench for the protocol-aware countdown timer
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] readdata;
  logic waitrequest;
  pct_pkg::pct_proto_t proto = '0;
  logic sig = 1'b1;
  logic aux = 1'b1;
  logic adr = 1'b1;
  logic timer_running_flag;
  logic expiry_flag;
  logic irq;
  int mismatches = 0;
  int n_compared = 0;
  logic p106 = 1'b0;
  logic [7:0] rd;
  logic [15:0] c1;
  logic [15:0] c2;
  int t0;
  int t3;
  int p;
  int big_p;
  int exp_t;
  int shadow [64];
  localparam logic [5:0] RW_IDS [7] = '{pct_pkg::IDX_MODE,
    pct_pkg::IDX_PSC_LO, pct_pkg::IDX_RLD_HI, pct_pkg::IDX_RLD_LO,
    pct_pkg::IDX_CFG, pct_pkg::IDX_RXMODE, pct_pkg::IDX_MASK};
  localparam logic [5:0] IDS [9] = '{pct_pkg::IDX_MODE, pct_pkg::IDX_PSC_LO,
    pct_pkg::IDX_RLD_HI, pct_pkg::IDX_RLD_LO, pct_pkg::IDX_CFG,
    pct_pkg::IDX_CNT_HI, pct_pkg::IDX_CNT_LO, pct_pkg::IDX_STS, 6'h3f};

  always #50 mclk = ~mclk;

  pct_timer dut (.mclk(mclk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .proto(proto),
    .signal_input_pin(sig), .auxiliary_pin_one(aux),
    .address_pin_three(adr), .timer_running_flag(timer_running_flag),
    .expiry_flag(expiry_flag), .irq(irq));

  task give_verdict;
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  task check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Register model: keeps writable bits only, strobes and counts drop out
  function automatic void model_wr(input logic [5:0] idx,
                                   input logic [7:0] d);
    case (idx)
      pct_pkg::IDX_MODE, pct_pkg::IDX_PSC_LO, pct_pkg::IDX_RLD_HI,
      pct_pkg::IDX_RLD_LO, pct_pkg::IDX_MASK: shadow[idx] = d;
      pct_pkg::IDX_CFG: begin
        shadow[idx] = (d[pct_pkg::CFG_EVEN_BIT] << pct_pkg::CFG_EVEN_BIT) |
                      (d[pct_pkg::CFG_RFON_BIT] << pct_pkg::CFG_RFON_BIT);
      end
      pct_pkg::IDX_RXMODE: begin
        shadow[idx] = d[pct_pkg::RXMODE_MULT_BIT] << pct_pkg::RXMODE_MULT_BIT;
      end
      default: ;
    endcase
  endfunction : model_wr

  // Entered just after a rising edge; returns one edge after release so
  // the next call never reassigns a strobe in the same time step
  task bus(input logic wr, input logic [5:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    address <= {idx, 2'b00};
    writedata <= {24'h0, d};
    byteenable <= 4'hf;
    write <= wr;
    read <= !wr;
    @(posedge mclk);
    while (waitrequest !== 1'b0) begin
      n++;
      if (n > 20) begin
        mismatches++;
        give_verdict();
      end
      @(posedge mclk);
    end
    rd = readdata[7:0];
    if (wr) begin
      model_wr(idx, d);
    end
    read <= 1'b0;
    write <= 1'b0;
    @(posedge mclk);
  endtask : bus

  task rd_chk(input logic [5:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check({8'h00, rd}, {8'h00, exp});
  endtask : rd_chk

  task rd_cnt(output logic [15:0] c);
    bus(1'b0, pct_pkg::IDX_CNT_HI, 8'h00);
    c[15:8] = rd;
    bus(1'b0, pct_pkg::IDX_CNT_LO, 8'h00);
    c[7:0] = rd;
  endtask : rd_cnt

  task pulse(input logic [2:0] m);
    proto <= {m, p106};
    @(posedge mclk);
    proto <= {3'b000, p106};
    repeat (2) @(posedge mclk);
  endtask : pulse

  // Cycles from the start write to expiry; fixed offsets cancel out
  task run_exp(output int t);
    t = 0;
    bus(1'b1, pct_pkg::IDX_CTRL, 8'h40);
    while (expiry_flag !== 1'b1) begin
      @(negedge mclk);
      t++;
      if (t > 20000) begin
        mismatches++;
        give_verdict();
      end
    end
    @(posedge mclk);
  endtask : run_exp

  initial begin
    void'($urandom(32'h579022a8));
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 9; i++) begin
      rd_chk(IDS[i], 8'h00);
    end
    check(timer_running_flag, 1'b0);
    p = $urandom_range(255);
    bus(1'b1, pct_pkg::IDX_PSC_LO, p[7:0]);
    rd_chk(pct_pkg::IDX_PSC_LO, p[7:0]);
    bus(1'b1, pct_pkg::IDX_RLD_HI, ~p[7:0]);
    rd_chk(pct_pkg::IDX_RLD_HI, ~p[7:0]);
    bus(1'b1, pct_pkg::IDX_CNT_HI, 8'h5a);
    rd_chk(pct_pkg::IDX_CNT_HI, 8'h00);
    bus(1'b1, pct_pkg::IDX_MASK, 8'h01);
    // Odd, even with the high nibble, then the shortest even period
    for (int e = 0; e < 3; e++) begin
      p = (e == 2) ? 0 : $urandom_range(7, 1);
      big_p = (e == 1) ? 256 + p : p;
      bus(1'b1, pct_pkg::IDX_CFG, (e > 0) ? 8'h01 : 8'h00);
      bus(1'b1, pct_pkg::IDX_MODE, (e == 1) ? 8'h01 : 8'h00);
      bus(1'b1, pct_pkg::IDX_PSC_LO, p[7:0]);
      bus(1'b1, pct_pkg::IDX_RLD_HI, 8'h00);
      bus(1'b1, pct_pkg::IDX_RLD_LO, 8'h00);
      run_exp(t0);
      check(irq, 1'b1);
      rd_chk(pct_pkg::IDX_STS, 8'h01);
      check(irq, 1'b0);
      bus(1'b1, pct_pkg::IDX_RLD_LO, 8'h03);
      run_exp(t3);
      rd_chk(pct_pkg::IDX_STS, 8'h01);
      exp_t = 3 * (2 * big_p + 1 + ((e > 0) ? 1 : 0));
      check(16'(t3 - t0), 16'(exp_t));
    end
    bus(1'b1, pct_pkg::IDX_CFG, 8'h00);
    bus(1'b1, pct_pkg::IDX_MODE, 8'h10);
    bus(1'b1, pct_pkg::IDX_PSC_LO, 8'h01);
    bus(1'b1, pct_pkg::IDX_RLD_LO, 8'h02);
    run_exp(t0);
    check(timer_running_flag, 1'b1);
    bus(1'b1, pct_pkg::IDX_CTRL, 8'h80);
    check(timer_running_flag, 1'b0);
    rd_cnt(c1);
    repeat (20) @(posedge mclk);
    rd_cnt(c2);
    check(c2, c1);
    bus(1'b0, pct_pkg::IDX_STS, 8'h00);
    // Selected pin low freezes the count while the other two pins are held high
    for (int g = 1; g < 4; g++) begin
      sig <= (g != 1);
      aux <= (g != 2);
      adr <= (g != 3);
      bus(1'b1, pct_pkg::IDX_MODE, {1'b0, g[1:0], 5'h00});
      bus(1'b1, pct_pkg::IDX_RLD_HI, 8'h40);
      bus(1'b1, pct_pkg::IDX_RLD_LO, 8'h00);
      bus(1'b1, pct_pkg::IDX_CTRL, 8'h40);
      bus(1'b1, pct_pkg::IDX_RLD_HI, 8'h7f);
      rd_cnt(c1);
      check(c1, 16'h4000);
      check(timer_running_flag, 1'b1);
      rd_chk(pct_pkg::IDX_STS, 8'(1 << pct_pkg::STS_RUN_BIT));
      {sig, aux, adr} <= 3'b111;
      repeat (10) @(posedge mclk);
      rd_cnt(c2);
      check(c2 < c1, 1'b1);
      bus(1'b1, pct_pkg::IDX_CTRL, 8'h80);
    end
    bus(1'b1, pct_pkg::IDX_RLD_HI, 8'h40);
    bus(1'b1, pct_pkg::IDX_CFG, 8'h02);
    bus(1'b1, pct_pkg::IDX_MODE, 8'h00);
    pulse(3'b100);
    pulse(3'b010);
    check(timer_running_flag, 1'b0);
    bus(1'b1, pct_pkg::IDX_CTRL, 8'h40);
    repeat (5) pulse(3'b001);
    check(timer_running_flag, 1'b1);
    bus(1'b1, pct_pkg::IDX_CTRL, 8'h80);
    bus(1'b1, pct_pkg::IDX_MODE, 8'h80);
    // Cases: other mode, 106k mode, receive-multiple set
    for (int k = 0; k < 3; k++) begin
      p106 <= (k == 1);
      bus(1'b1, pct_pkg::IDX_RXMODE, (k == 2) ? 8'h04 : 8'h00);
      pulse((k == 1) ? 3'b010 : 3'b100);
      check(timer_running_flag, 1'b1);
      repeat ((k == 1) ? 4 : 3) pulse(3'b001);
      check(timer_running_flag, 1'b1);
      pulse(3'b001);
      check(timer_running_flag, k == 2);
      pulse(3'b001);
      check(timer_running_flag, k == 2);
      bus(1'b1, pct_pkg::IDX_CTRL, 8'h80);
    end
    bus(1'b1, pct_pkg::IDX_CFG, 8'h00);
    pulse(3'b010);
    check(timer_running_flag, 1'b0);
    for (int i = 0; i < 7; i++) begin
      rd_chk(RW_IDS[i], shadow[RW_IDS[i]][7:0]);
    end
    give_verdict();
  end
endmodule : testbench
